/* csmux_regs.svh */
/*
 * Register offsets, field positions, reset values and masks of the clock
 * source selector block.
 * Assumes byte addresses on a 32-bit APB with one word per register.
 */
`ifndef CSMUX_REGS_SVH
`define CSMUX_REGS_SVH

// Register byte offsets
`define CSMUX_OFF_GATE_ENABLE_BANK1     12'h204
`define CSMUX_OFF_GATE_CLEAR_BANK1      12'h244
`define CSMUX_OFF_MAIN_SEL_FIRST        12'h280
`define CSMUX_OFF_MAIN_SEL_SECOND       12'h284
`define CSMUX_OFF_CLOCK_OUTPUT_PIN_SEL            12'h288
`define CSMUX_OFF_PLL_REF_SEL           12'h290
`define CSMUX_OFF_CONV_SEL              12'h2A4
`define CSMUX_OFF_SWITCH_STATUS         12'h300

// Field widths of the selector registers
`define CSMUX_MAIN_SEL_W                2
`define CSMUX_AUX_SEL_W                 3

// Reset values
`define CSMUX_RST_GATE_ENABLE_BANK1     32'h0000_0000
`define CSMUX_RST_MAIN_SEL              2'h0
`define CSMUX_RST_AUX_SEL               3'h7

// Gate-enable bits present in bank one
`define CSMUX_GATE1_IMPL_MASK           32'h0E4F_FC05

// Main selector codes
`define CSMUX_A_OSC_LOW                 2'h0
`define CSMUX_A_CLK_IN                  2'h1
`define CSMUX_A_WDT                     2'h2
`define CSMUX_A_OSC_HIGH                2'h3
`define CSMUX_B_FIRST                   2'h0
`define CSMUX_B_RESERVED                2'h1
`define CSMUX_B_PLL                     2'h2
`define CSMUX_B_RTC                     2'h3

// Code that stops an auxiliary selector output
`define CSMUX_AUX_NONE                  3'h7

// Status register field positions
`define CSMUX_STAT_A_ACTIVE_LSB         0
`define CSMUX_STAT_A_BUSY_BIT           2
`define CSMUX_STAT_B_ACTIVE_LSB         4
`define CSMUX_STAT_B_BUSY_BIT           6

// Source vector indices
`define CSMUX_SRC_OSC_LOW               0
`define CSMUX_SRC_CLK_IN                1
`define CSMUX_SRC_WDT                   2
`define CSMUX_SRC_OSC_HIGH              3
`define CSMUX_SRC_PLL                   4
`define CSMUX_SRC_RTC                   5
`define CSMUX_SRC_COUNT                 6

`endif

/* csmux_pkg.sv */
/*
 * Types of the clock source selector block: switch states and the packed
 * state record of the top module.
 * Assumes csmux_regs.svh is on the include path.
 */
`include "csmux_regs.svh"

package csmux_pkg;

    // Phases of a glitch-free switch
    typedef enum logic [1:0]
    {
        SW_RUN,
        SW_DRAIN,
        SW_WAIT
    } csmux_sw_state_t;

    // One glitch-free switcher
    typedef struct packed
    {
        logic [`CSMUX_MAIN_SEL_W-1:0] cur;
        csmux_sw_state_t              st;
        logic                         gate;
    } csmux_sw_t;

    // Whole state of the top module
    typedef struct packed
    {
        logic [31:0]                  gate1;
        logic [`CSMUX_MAIN_SEL_W-1:0] sel_a;
        logic [`CSMUX_MAIN_SEL_W-1:0] sel_b;
        logic [`CSMUX_AUX_SEL_W-1:0]  sel_clock_output_pin;
        logic [`CSMUX_AUX_SEL_W-1:0]  sel_pllref;
        logic [`CSMUX_AUX_SEL_W-1:0]  sel_conv;
        logic [31:0]                  prdata;
        csmux_sw_t                    sw_a;
        csmux_sw_t                    sw_b;
        logic                         out_a;
        logic                         out_main;
        logic                         out_clock_output_pin;
        logic                         out_pllref;
        logic                         out_conv;
    } csmux_state_t;

endpackage

/* csmux_sync.sv */
/*
 * Two-stage synchroniser for a vector of independent levels.
 * Assumes each bit is sampled on its own; no bit relation is kept.
 */
module csmux_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_reset,
    // Levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

/* csmux_top.sv */
/*
 * Clock source selectors: two-stage glitch-free main selector, clock-output,
 * PLL reference and converter selectors, and the bank-one gate register
 * with its write-one-to-clear companion, all behind an APB slave.
 * Assumes source clocks are far slower than i_core_clk and arrive as
 * levels that are synchronised here; outputs are oversampled clock levels.
 */
`include "csmux_regs.svh"

module csmux_top
    import csmux_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_reset,
    // APB slave
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [ADDR_W-1:0]     i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic      [31:0]           o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    // Source clocks, index order in csmux_regs.svh
    input  wire logic [`CSMUX_SRC_COUNT-1:0] i_src_clk,
    // Selected clocks
    output logic                       o_main_clk,
    output logic                       o_clock_output_pin,
    output logic                       o_pll_ref_clk,
    output logic                       o_converter_clk,
    // Peripheral clock enables
    output logic      [31:0]           o_gate_enable_bank1
);

    csmux_state_t                  s_q;
    csmux_state_t                  s_d;
    logic [`CSMUX_SRC_COUNT-1:0]   src;
    logic                          setup_phase;
    logic                          access_wr;
    logic                          addr_ok;
    logic [ADDR_W-1:0]             addr_setup;

    // Source clocks pass two flip-flops before any logic
    csmux_sync #(
        .WIDTH (`CSMUX_SRC_COUNT)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_async    (i_src_clk),
        .o_sync     (src)
    );

    // Level of the first main selector for a code
    function automatic logic lvl_first(input logic [`CSMUX_MAIN_SEL_W-1:0] code,
                                       input logic [`CSMUX_SRC_COUNT-1:0] s);
        logic l;
        l = 1'b0;
        case (code)
            `CSMUX_A_OSC_LOW:  l = s[`CSMUX_SRC_OSC_LOW];
            `CSMUX_A_CLK_IN:   l = s[`CSMUX_SRC_CLK_IN];
            `CSMUX_A_WDT:      l = s[`CSMUX_SRC_WDT];
            default:           l = s[`CSMUX_SRC_OSC_HIGH];
        endcase
        return l;
    endfunction

    // Level of the second main selector for a code
    function automatic logic lvl_second(input logic [`CSMUX_MAIN_SEL_W-1:0] code,
                                        input logic [`CSMUX_SRC_COUNT-1:0] s,
                                        input logic first);
        logic l;
        l = 1'b0;
        case (code)
            `CSMUX_B_FIRST:    l = first;
            `CSMUX_B_PLL:      l = s[`CSMUX_SRC_PLL];
            `CSMUX_B_RTC:      l = s[`CSMUX_SRC_RTC];
            default:           l = 1'b0;
        endcase
        return l;
    endfunction

    // One step of a glitch-free switch: drain old clock low, then new
    function automatic csmux_sw_t sw_step(input csmux_sw_t sw,
                                          input logic [`CSMUX_MAIN_SEL_W-1:0] req,
                                          input logic lvl_old,
                                          input logic lvl_new);
        csmux_sw_t n;
        n = sw;
        case (sw.st)
            SW_RUN:
            begin
                if (req != sw.cur)
                    n.st = SW_DRAIN;
            end
            SW_DRAIN:
            begin
                // Gate off only while the old clock sits low
                if (!lvl_old)
                begin
                    n.gate = 1'b0;
                    n.cur  = req;
                    n.st   = SW_WAIT;
                end
            end
            SW_WAIT:
            begin
                // Gate on only while the new clock sits low
                if (!lvl_new)
                begin
                    n.gate = 1'b1;
                    n.st   = SW_RUN;
                end
            end
            default:
            begin
                n.st = SW_RUN;
            end
        endcase
        return n;
    endfunction

    // APB decode
    assign setup_phase = i_psel && !i_penable;
    assign access_wr   = i_psel && i_penable && i_pwrite;
    assign addr_setup  = i_paddr;

    // Mapped addresses
    always_comb
    begin
        addr_ok = 1'b1;
        if (i_paddr == ADDR_W'(`CSMUX_OFF_GATE_ENABLE_BANK1))
            addr_ok = 1'b1;
        else if (i_paddr == ADDR_W'(`CSMUX_OFF_GATE_CLEAR_BANK1))
            addr_ok = 1'b1;
        else if (i_paddr == ADDR_W'(`CSMUX_OFF_MAIN_SEL_FIRST))
            addr_ok = 1'b1;
        else if (i_paddr == ADDR_W'(`CSMUX_OFF_MAIN_SEL_SECOND))
            addr_ok = 1'b1;
        else if (i_paddr == ADDR_W'(`CSMUX_OFF_CLOCK_OUTPUT_PIN_SEL))
            addr_ok = 1'b1;
        else if (i_paddr == ADDR_W'(`CSMUX_OFF_PLL_REF_SEL))
            addr_ok = 1'b1;
        else if (i_paddr == ADDR_W'(`CSMUX_OFF_CONV_SEL))
            addr_ok = 1'b1;
        else if (i_paddr == ADDR_W'(`CSMUX_OFF_SWITCH_STATUS))
            addr_ok = 1'b1;
        else
            addr_ok = 1'b0;
    end

    // Next state
    always_comb
    begin
        logic lvl_a_old;
        logic lvl_a_new;
        logic lvl_b_old;
        logic lvl_b_new;
        lvl_a_old = 1'b0;
        lvl_a_new = 1'b0;
        lvl_b_old = 1'b0;
        lvl_b_new = 1'b0;
        s_d = s_q;

        // Register writes, taken in the access phase
        if (access_wr)
        begin
            if (i_paddr == ADDR_W'(`CSMUX_OFF_GATE_ENABLE_BANK1))
                s_d.gate1 = i_pwdata & `CSMUX_GATE1_IMPL_MASK;
            else if (i_paddr == ADDR_W'(`CSMUX_OFF_GATE_CLEAR_BANK1))
                s_d.gate1 = s_q.gate1 & ~(i_pwdata & `CSMUX_GATE1_IMPL_MASK);
            else if (i_paddr == ADDR_W'(`CSMUX_OFF_MAIN_SEL_FIRST))
                s_d.sel_a = i_pwdata[`CSMUX_MAIN_SEL_W-1:0];
            else if (i_paddr == ADDR_W'(`CSMUX_OFF_MAIN_SEL_SECOND))
                s_d.sel_b = i_pwdata[`CSMUX_MAIN_SEL_W-1:0];
            else if (i_paddr == ADDR_W'(`CSMUX_OFF_CLOCK_OUTPUT_PIN_SEL))
                s_d.sel_clock_output_pin = i_pwdata[`CSMUX_AUX_SEL_W-1:0];
            else if (i_paddr == ADDR_W'(`CSMUX_OFF_PLL_REF_SEL))
                s_d.sel_pllref = i_pwdata[`CSMUX_AUX_SEL_W-1:0];
            else if (i_paddr == ADDR_W'(`CSMUX_OFF_CONV_SEL))
                s_d.sel_conv = i_pwdata[`CSMUX_AUX_SEL_W-1:0];
        end

        // Read data captured in the setup phase
        if (setup_phase)
        begin
            s_d.prdata = 32'h0000_0000;
            if (addr_setup == ADDR_W'(`CSMUX_OFF_GATE_ENABLE_BANK1))
                s_d.prdata = s_q.gate1;
            else if (addr_setup == ADDR_W'(`CSMUX_OFF_MAIN_SEL_FIRST))
                s_d.prdata = {30'h0000_0000, s_q.sel_a};
            else if (addr_setup == ADDR_W'(`CSMUX_OFF_MAIN_SEL_SECOND))
                s_d.prdata = {30'h0000_0000, s_q.sel_b};
            else if (addr_setup == ADDR_W'(`CSMUX_OFF_CLOCK_OUTPUT_PIN_SEL))
                s_d.prdata = {29'h0000_0000, s_q.sel_clock_output_pin};
            else if (addr_setup == ADDR_W'(`CSMUX_OFF_PLL_REF_SEL))
                s_d.prdata = {29'h0000_0000, s_q.sel_pllref};
            else if (addr_setup == ADDR_W'(`CSMUX_OFF_CONV_SEL))
                s_d.prdata = {29'h0000_0000, s_q.sel_conv};
            else if (addr_setup == ADDR_W'(`CSMUX_OFF_SWITCH_STATUS))
            begin
                s_d.prdata[`CSMUX_STAT_A_ACTIVE_LSB +: `CSMUX_MAIN_SEL_W] = s_q.sw_a.cur;
                s_d.prdata[`CSMUX_STAT_A_BUSY_BIT] = (s_q.sw_a.st != SW_RUN);
                s_d.prdata[`CSMUX_STAT_B_ACTIVE_LSB +: `CSMUX_MAIN_SEL_W] = s_q.sw_b.cur;
                s_d.prdata[`CSMUX_STAT_B_BUSY_BIT] = (s_q.sw_b.st != SW_RUN);
            end
        end

        // Glitch-free main switchers
        lvl_a_old = lvl_first(s_q.sw_a.cur, src);
        lvl_a_new = lvl_first(s_q.sw_a.cur, src);       // In WAIT cur already holds the new code
        s_d.sw_a  = sw_step(s_q.sw_a, s_q.sel_a, lvl_a_old, lvl_a_new);
        lvl_b_old = lvl_second(s_q.sw_b.cur, src, s_q.out_a);
        lvl_b_new = lvl_second(s_q.sw_b.cur, src, s_q.out_a);
        s_d.sw_b  = sw_step(s_q.sw_b, s_q.sel_b, lvl_b_old, lvl_b_new);

        // Gated main outputs
        s_d.out_a    = s_d.sw_a.gate && lvl_first(s_d.sw_a.cur, src);
        s_d.out_main = s_d.sw_b.gate && lvl_second(s_d.sw_b.cur, src, s_q.out_a);

        // Clock-output pin selector
        case (s_q.sel_clock_output_pin)
            3'h0:    s_d.out_clock_output_pin = s_q.out_main;
            3'h1:    s_d.out_clock_output_pin = src[`CSMUX_SRC_CLK_IN];
            3'h2:    s_d.out_clock_output_pin = src[`CSMUX_SRC_WDT];
            3'h3:    s_d.out_clock_output_pin = src[`CSMUX_SRC_OSC_HIGH];
            3'h4:    s_d.out_clock_output_pin = src[`CSMUX_SRC_PLL];
            3'h5:    s_d.out_clock_output_pin = src[`CSMUX_SRC_OSC_LOW];
            3'h6:    s_d.out_clock_output_pin = src[`CSMUX_SRC_RTC];
            default: s_d.out_clock_output_pin = 1'b0;
        endcase

        // PLL reference selector
        case (s_q.sel_pllref)
            3'h0:    s_d.out_pllref = src[`CSMUX_SRC_OSC_LOW];
            3'h1:    s_d.out_pllref = src[`CSMUX_SRC_CLK_IN];
            3'h3:    s_d.out_pllref = src[`CSMUX_SRC_RTC];
            default: s_d.out_pllref = 1'b0;
        endcase

        // Converter clock selector
        case (s_q.sel_conv)
            3'h0:    s_d.out_conv = s_q.out_main;
            3'h1:    s_d.out_conv = src[`CSMUX_SRC_PLL];
            3'h2:    s_d.out_conv = src[`CSMUX_SRC_OSC_HIGH];
            default: s_d.out_conv = 1'b0;
        endcase
    end

    // State register
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            s_q            <= '0;
            s_q.gate1      <= `CSMUX_RST_GATE_ENABLE_BANK1;
            s_q.sel_a      <= `CSMUX_RST_MAIN_SEL;
            s_q.sel_b      <= `CSMUX_RST_MAIN_SEL;
            s_q.sel_clock_output_pin <= `CSMUX_RST_AUX_SEL;
            s_q.sel_pllref <= `CSMUX_RST_AUX_SEL;
            s_q.sel_conv   <= `CSMUX_RST_AUX_SEL;
            s_q.sw_a.cur   <= `CSMUX_RST_MAIN_SEL;
            s_q.sw_a.st    <= SW_RUN;
            s_q.sw_a.gate  <= 1'b1;
            s_q.sw_b.cur   <= `CSMUX_RST_MAIN_SEL;
            s_q.sw_b.st    <= SW_RUN;
            s_q.sw_b.gate  <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign o_prdata            = s_q.prdata;
    assign o_pready            = 1'b1;
    assign o_pslverr           = i_psel && i_penable && !addr_ok;
    assign o_main_clk          = s_q.out_main;
    assign o_clock_output_pin  = s_q.out_clock_output_pin;
    assign o_pll_ref_clk       = s_q.out_pllref;
    assign o_converter_clk     = s_q.out_conv;
    assign o_gate_enable_bank1 = s_q.gate1;

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    logic wr_clr;
    logic rd_clr;
    assign wr_clr = access_wr && (i_paddr == ADDR_W'(`CSMUX_OFF_GATE_CLEAR_BANK1));
    assign rd_clr = i_psel && i_penable && !i_pwrite
                    && (i_paddr == ADDR_W'(`CSMUX_OFF_GATE_CLEAR_BANK1));

    sequence seq_switch_req;
        (s_q.sw_a.st == SW_RUN) && (s_q.sel_a != s_q.sw_a.cur);
    endsequence

    sequence seq_drain;
        (s_q.sw_a.st == SW_DRAIN);
    endsequence

    a_gate_clear_ones: assert property (wr_clr |=> (o_gate_enable_bank1 & $past(i_pwdata)) == 32'h0000_0000)
        else $error("clear write left an enable set");
    a_gate_clear_zeros: assert property (wr_clr |=> (o_gate_enable_bank1 | $past(i_pwdata))
        == ($past(o_gate_enable_bank1) | $past(i_pwdata)))
        else $error("clear write changed an unselected enable");
    a_clear_reads_zero: assert property (rd_clr |-> o_prdata == 32'h0000_0000)
        else $error("clear register returned data");
    a_main_switch_start: assert property (seq_switch_req |=> seq_drain)
        else $error("first selector did not begin draining");
    a_main_switch_dark: assert property ((s_q.sw_a.st == SW_WAIT) |=> !s_q.out_a)
        else $error("first selector output ran while switching");
    a_main_reserved: assert property ((s_q.sw_b.cur == `CSMUX_B_RESERVED) && (s_q.sw_b.st == SW_RUN)
        ##1 (s_q.sw_b.cur == `CSMUX_B_RESERVED) |-> !o_main_clk)
        else $error("reserved main code delivered a clock");
    a_clock_output_pin_none: assert property ((s_q.sel_clock_output_pin == `CSMUX_AUX_NONE) |=> !o_clock_output_pin)
        else $error("clock output ran with none selected");
    a_pllref_reserved: assert property ((s_q.sel_pllref == 3'h2) |=> !o_pll_ref_clk)
        else $error("reserved PLL reference code delivered a clock");
    a_conv_none: assert property ((s_q.sel_conv == `CSMUX_AUX_NONE) |=> !o_converter_clk)
        else $error("converter clock ran with none selected");
    a_sel_reset: assert property ($fell(i_reset) |-> (s_q.sel_a == `CSMUX_RST_MAIN_SEL)
        && (s_q.sel_clock_output_pin == `CSMUX_RST_AUX_SEL))
        else $error("selector reset value wrong");

endmodule

/* tb_csmux_top.sv */
/*
 * Self-checking bench of the clock source selector block: register map,
 * gate clear, main selector switching and the three auxiliary selectors.
 * Assumes csmux_regs.svh, csmux_pkg.sv, csmux_sync.sv and csmux_top.sv are
 * compiled first; source clocks are slow levels made here.
 */
`include "csmux_regs.svh"

module tb_csmux_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_core_clk = 1'b0;
    logic        i_reset    = 1'b1;
    logic        i_psel     = 1'b0;
    logic        i_penable  = 1'b0;
    logic        i_pwrite   = 1'b0;
    logic [11:0] i_paddr    = 12'h000;
    logic [31:0] i_pwdata   = 32'h0000_0000;
    logic [5:0]  i_src_clk  = 6'h00;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        o_main_clk;
    logic        o_clock_output_pin;
    logic        o_pll_ref_clk;
    logic        o_converter_clk;
    logic [31:0] o_gate_enable_bank1;
    logic [3:0]  outs;
    logic [3:0]  outs_q     = 4'h0;
    logic        meas       = 1'b0;
    logic [31:0] rd;
    logic        err;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles     = 0;
    int          high_run   = 0;
    int          div [6];
    int          cnt [4];

    csmux_top #(.ADDR_W(12)) dut_u (
        .i_core_clk(i_core_clk), .i_reset(i_reset), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_src_clk(i_src_clk), .o_main_clk(o_main_clk),
        .o_clock_output_pin(o_clock_output_pin), .o_pll_ref_clk(o_pll_ref_clk),
        .o_converter_clk(o_converter_clk), .o_gate_enable_bank1(o_gate_enable_bank1)
    );

    assign outs = {o_converter_clk, o_pll_ref_clk, o_clock_output_pin, o_main_clk};

    // Core clock, 8 ns period
    always #4 i_core_clk = ~i_core_clk;

    // Slow source clocks: source k has a half period of k+2 core cycles
    always @(posedge i_core_clk)
    begin
        for (int k = 0; k < 6; k++)
        begin
            if (div[k] == k + 1)
            begin
                div[k] <= 0;
                i_src_clk[k] <= ~i_src_clk[k];
            end
            else
                div[k] <= div[k] + 1;
        end
    end

    // Toggle counting, short high pulse watch on the main clock, timeout
    always @(posedge i_core_clk)
    begin
        cycles <= cycles + 1;
        outs_q <= outs;
        for (int k = 0; k < 4; k++)
            if (meas && outs_q[k] !== outs[k]) cnt[k] <= cnt[k] + 1;
        if (o_main_clk === 1'b1)
            high_run <= high_run + 1;
        else
        begin
            if (outs_q[0] === 1'b1 && !i_reset)
                chk(32'(high_run >= 2), 32'h0000_0001);
            high_run <= 0;
        end
        if (cycles == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        @(posedge i_core_clk);
        while (o_pready !== 1'b1)
            @(posedge i_core_clk);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    // Count output toggles over 420 cycles, a multiple of every source half period
    task automatic measure();
        @(posedge i_core_clk);
        foreach (cnt[k]) cnt[k] <= 0;
        meas <= 1'b1;
        repeat (420) @(posedge i_core_clk);
        meas <= 1'b0;
        @(posedge i_core_clk);
    endtask

    // Expected toggles of source idx, none when idx is negative; window is whole half periods
    function automatic logic [31:0] toggles(input int idx);
        return (idx < 0) ? 32'h0000_0000 : 32'(420 / (idx + 2));
    endfunction

    task automatic t_reset();
        apb(1'b0, `CSMUX_OFF_MAIN_SEL_FIRST, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, `CSMUX_OFF_MAIN_SEL_SECOND, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, `CSMUX_OFF_CLOCK_OUTPUT_PIN_SEL, 32'h0);
        chk(rd, 32'h0000_0007);
        apb(1'b0, `CSMUX_OFF_PLL_REF_SEL, 32'h0);
        chk(rd, 32'h0000_0007);
        apb(1'b0, `CSMUX_OFF_CONV_SEL, 32'h0);
        chk(rd, 32'h0000_0007);
        chk(o_gate_enable_bank1, 32'h0000_0000);
        apb(1'b0, 12'h100, 32'h0);
        chk({rd[30:0], err}, 32'h0000_0001);
    endtask

    task automatic t_gate();
        apb(1'b1, `CSMUX_OFF_GATE_ENABLE_BANK1, 32'hFFFF_FFFF);
        apb(1'b0, `CSMUX_OFF_GATE_ENABLE_BANK1, 32'h0);
        chk(rd, 32'h0E4F_FC05);
        apb(1'b1, `CSMUX_OFF_GATE_CLEAR_BANK1, 32'h0040_0C01);
        #1;
        chk(o_gate_enable_bank1, 32'h0E0F_F004);
        apb(1'b0, `CSMUX_OFF_GATE_CLEAR_BANK1, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b1, `CSMUX_OFF_GATE_CLEAR_BANK1, 32'h0E4F_FC05);
        apb(1'b0, `CSMUX_OFF_GATE_ENABLE_BANK1, 32'h0);
        chk(rd, 32'h0000_0000);
    endtask

    task automatic t_main();
        int b_code [4] = '{2, 3, 1, 0};
        int b_idx [4] = '{4, 5, -1, 0};
        for (int a = 3; a >= 0; a--)
        begin
            apb(1'b1, `CSMUX_OFF_MAIN_SEL_FIRST, 32'(a));
            repeat (40) @(posedge i_core_clk);
            measure();
            chk(cnt[0], toggles(a));
            apb(1'b0, `CSMUX_OFF_SWITCH_STATUS, 32'h0);
            chk(rd, 32'(a));
        end
        foreach (b_code[i])
        begin
            apb(1'b1, `CSMUX_OFF_MAIN_SEL_SECOND, 32'(b_code[i]));
            repeat (40) @(posedge i_core_clk);
            measure();
            chk(cnt[0], toggles(b_idx[i]));
            apb(1'b0, `CSMUX_OFF_SWITCH_STATUS, 32'h0);
            chk(rd, 32'(b_code[i] << 4));
        end
    endtask

    // Main clock runs from the clock input while the auxiliary selectors step
    task automatic t_aux();
        int m_out [8] = '{1, 1, 2, 3, 4, 0, 5, -1};
        int m_pll [8] = '{0, 1, -1, 5, -1, -1, -1, -1};
        int m_cnv [8] = '{1, 4, 3, -1, -1, -1, -1, -1};
        apb(1'b1, `CSMUX_OFF_MAIN_SEL_FIRST, 32'h0000_0001);
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, `CSMUX_OFF_CLOCK_OUTPUT_PIN_SEL, 32'(c));
            apb(1'b1, `CSMUX_OFF_PLL_REF_SEL, 32'(c));
            apb(1'b1, `CSMUX_OFF_CONV_SEL, 32'(c));
            apb(1'b0, `CSMUX_OFF_PLL_REF_SEL, 32'h0);
            chk(rd, 32'(c));
            repeat (40) @(posedge i_core_clk);
            measure();
            chk(cnt[1], toggles(m_out[c]));
            chk(cnt[2], toggles(m_pll[c]));
            chk(cnt[3], toggles(m_cnv[c]));
        end
    endtask

    task automatic end_sim();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Reset for two cycles, then the scenarios in turn
    initial
    begin
        repeat (2) @(posedge i_core_clk);
        i_reset <= 1'b0;
        t_reset();
        t_gate();
        t_main();
        t_aux();
        end_sim();
    end
endmodule
